// >>> verilog/pbr_master.sv
// Read-side bus master: single and line reads, burst and burst-inhibited
// How it works
// - Start strobe drops after the first clock
// - Slave places operand on lanes by size
// - First sample after start ends cycle on acknowledge
// - No acknowledge: discard data, wait, resample
// - Progress flag held if next request ready
// - Line is four aligned long words, any start
// - Slave wraps bits 3:2 within the line
// - Address steady in burst; slave acknowledges each word
// - Refused burst: three more long-word cycles
// - Burst-inhibited line stays locked and indivisible
// - Burst inhibit ignored after first word
// - Cache inhibit on first word latched, line completes
// - Cache inhibit ignored after first word
// - Low address bits copied, kept through line
// - Instruction-fetch lines start on half-line boundary
// - Line start: address, read, line size, strobe
// - Block-move noncachable line asserts cache inhibit out
// - Slave returns addressed word first, flags burst ability
// - First beat samples acknowledge and both inhibits
// - Inhibited line: master steps bits 3:2 itself
// - Zero-wait burst five clocks, inhibited eight
// - Later burst beats keep address, forward on acknowledge
`timescale 1ns/100ps
module pbr_master (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    pbr_if.master bus,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [31:0] reqAddr,
    input wire logic [1:0] reqSize,
    input wire logic reqLine,
    input wire logic reqFetch,
    input wire logic reqBlockMove,
    input wire logic reqNoCache,
    input wire logic [1:0] reqType,
    input wire logic [2:0] reqModifier,
    input wire logic [1:0] reqUserAttr,
    output logic rspValid,
    output logic [31:0] rspData,
    output logic rspCacheInhibit,
    output logic rspLast,
    output logic busLocked
);
    pbr_pkg::pbr_mst_state_e state_q;
    pbr_pkg::pbr_mst_state_e state_d;
    logic [31:0] addr_q;
    logic [1:0] size_q;
    logic line_q;
    logic inhib_q;
    logic cache_inhibit_out_q;
    logic [1:0] beat_q;
    logic [1:0] type_q;
    logic [2:0] mod_q;
    logic [1:0] userAttr_q;
    logic inProg_q;
    logic cacheInh_q;
    logic rspValid_q;
    logic [31:0] rspData_q;
    logic rspCacheInhibit_q;
    logic rspLast_q;
    logic ack;
    logic firstLineAck;
    logic lastBeat;
    logic finalAck;
    logic take;
    logic reStart;
    logic active;

    // Data is only looked at in the beat state; outside it the bus is not sampled
    assign ack = (state_q == pbr_pkg::MST_BEAT) && bus.transferAck;
    assign firstLineAck = ack && line_q && (beat_q == pbr_pkg::FIRST_BEAT);
    assign lastBeat = !line_q || (beat_q == pbr_pkg::LAST_BEAT);
    assign finalAck = ack && lastBeat;
    // A line never yields the bus between its long words
    assign reqReady = (state_q == pbr_pkg::MST_IDLE) || finalAck;
    assign take = reqValid && reqReady;
    // Burst inhibit counts only with the first acknowledge
    assign reStart = ack && line_q && !lastBeat
        && (inhib_q || ((beat_q == pbr_pkg::FIRST_BEAT) && bus.burstInhibit));
    assign active = (state_q != pbr_pkg::MST_IDLE);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pbr_pkg::MST_IDLE: begin
                state_d = take ? pbr_pkg::MST_START : pbr_pkg::MST_IDLE;
            end
            pbr_pkg::MST_START: begin
                state_d = pbr_pkg::MST_BEAT;
            end
            pbr_pkg::MST_BEAT: begin
                if (finalAck) begin
                    state_d = take ? pbr_pkg::MST_START : pbr_pkg::MST_IDLE;
                end else if (reStart) begin
                    state_d = pbr_pkg::MST_START;
                end else begin
                    state_d = pbr_pkg::MST_BEAT;
                end
            end
            default: begin
                state_d = pbr_pkg::MST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= pbr_pkg::MST_IDLE;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // Address and attributes stay put for a whole burst
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_q <= pbr_pkg::RESET_WORD;
            size_q <= pbr_pkg::SIZE_LONG;
            line_q <= 1'b0;
            cache_inhibit_out_q <= 1'b0;
            type_q <= 2'h0;
            mod_q <= 3'h0;
            userAttr_q <= 2'h0;
        end else if (clkEn) begin
            if (take) begin
                addr_q <= reqAddr;
                if (reqFetch && reqLine) begin
                    addr_q[pbr_pkg::HALF_LINE_LSBS-1:0] <= 3'h0;
                end
                size_q <= reqSize;
                line_q <= reqLine;
                cache_inhibit_out_q <= reqLine ? (reqBlockMove && reqNoCache) : 1'b1;
                type_q <= reqType;
                mod_q <= reqModifier;
                userAttr_q <= reqUserAttr;
            end else if (reStart) begin
                // Only bits 3:2 step; low bits keep the operand offset
                addr_q[pbr_pkg::LINE_ADDR_MSB:pbr_pkg::LINE_ADDR_LSB] <=
                    addr_q[pbr_pkg::LINE_ADDR_MSB:pbr_pkg::LINE_ADDR_LSB] + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            beat_q <= pbr_pkg::FIRST_BEAT;
            inhib_q <= 1'b0;
            cacheInh_q <= 1'b0;
        end else if (clkEn) begin
            if (take) begin
                beat_q <= pbr_pkg::FIRST_BEAT;
                inhib_q <= 1'b0;
                cacheInh_q <= 1'b0;
            end else begin
                if (ack && !lastBeat) begin
                    beat_q <= beat_q + 2'h1;
                end
                if (firstLineAck) begin
                    inhib_q <= bus.burstInhibit;
                    cacheInh_q <= bus.cacheInhibitIn;
                end
            end
        end
    end

    // Held across back-to-back cycles, dropped the clock after the last one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inProg_q <= 1'b0;
        end else if (clkEn) begin
            if (take) begin
                inProg_q <= 1'b1;
            end else if (finalAck) begin
                inProg_q <= 1'b0;
            end
        end
    end

    // Data is forwarded only with an acknowledge; other samples are dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rspValid_q <= 1'b0;
            rspData_q <= pbr_pkg::RESET_WORD;
            rspCacheInhibit_q <= 1'b0;
            rspLast_q <= 1'b0;
        end else if (clkEn) begin
            rspValid_q <= ack;
            rspLast_q <= finalAck;
            if (ack) begin
                rspData_q <= bus.data;
                // Single reads never fill a cache, so the level is not used
                rspCacheInhibit_q <= firstLineAck ? bus.cacheInhibitIn
                    : (line_q && cacheInh_q);
            end
        end
    end

    assign bus.busCycleStartStrobe = (state_q == pbr_pkg::MST_START);
    assign bus.cycleInProgress = inProg_q;
    assign bus.readWrite = 1'b1;
    assign bus.addr = addr_q;
    assign bus.sizeBits = line_q ? (inhib_q ? pbr_pkg::SIZE_LONG : pbr_pkg::SIZE_LINE)
        : size_q;
    assign bus.transferType = type_q;
    assign bus.transferModifier = mod_q;
    assign bus.userAttributeOutputs = userAttr_q;
    assign bus.cacheInhibitOut = active && cache_inhibit_out_q;
    assign busLocked = active && line_q;
    assign rspValid = rspValid_q;
    assign rspData = rspData_q;
    assign rspCacheInhibit = rspCacheInhibit_q;
    assign rspLast = rspLast_q;
endmodule

// >>> verilog/pbr_pkg.sv
// Shared encodings and counts for the processor bus read path
package pbr_pkg;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LINE = 2'h3;
    localparam logic [1:0] FIRST_BEAT = 2'h0;
    localparam logic [1:0] LAST_BEAT = 2'h3;
    localparam logic [2:0] LINE_WORDS = 3'h4;
    localparam logic [2:0] SINGLE_WORDS = 3'h1;
    localparam int LINE_ADDR_LSB = 2;
    localparam int LINE_ADDR_MSB = 3;
    localparam int HALF_LINE_LSBS = 3;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        MST_IDLE = 3'h1,
        MST_START = 3'h2,
        MST_BEAT = 3'h4
    } pbr_mst_state_e;
endpackage

// >>> verilog/pbr_if.sv
// Bus wires between the read master and the memory slave
`timescale 1ns/100ps
interface pbr_if;
    logic busCycleStartStrobe;
    logic cycleInProgress;
    logic readWrite;
    logic [1:0] sizeBits;
    logic [31:0] addr;
    logic [1:0] transferType;
    logic [2:0] transferModifier;
    logic [1:0] userAttributeOutputs;
    logic cacheInhibitOut;
    logic [31:0] data;
    logic transferAck;
    logic burstInhibit;
    logic cacheInhibitIn;

    modport master (
        output busCycleStartStrobe,
        output cycleInProgress,
        output readWrite,
        output sizeBits,
        output addr,
        output transferType,
        output transferModifier,
        output userAttributeOutputs,
        output cacheInhibitOut,
        input data,
        input transferAck,
        input burstInhibit,
        input cacheInhibitIn
    );

    modport slave (
        input busCycleStartStrobe,
        input cycleInProgress,
        input readWrite,
        input sizeBits,
        input addr,
        input transferType,
        input transferModifier,
        input userAttributeOutputs,
        input cacheInhibitOut,
        output data,
        output transferAck,
        output burstInhibit,
        output cacheInhibitIn
    );
endinterface

// >>> verilog/pbr_slave.sv
// Memory slave end: answers single and line reads from a word memory port
`timescale 1ns/100ps
module pbr_slave (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clkEn,
    pbr_if.slave bus,
    input wire logic canBurst,
    input wire logic noCache,
    output logic memReqValid,
    input wire logic memReqReady,
    output logic [31:0] memReqAddr,
    input wire logic memRspValid,
    output logic memRspReady,
    input wire logic [31:0] memRspData
);
    logic active_q;
    logic burst_q;
    logic line_q;
    logic first_q;
    logic [2:0] beatsLeft_q;
    logic [2:0] reqLeft_q;
    logic [31:0] reqAddr_q;
    logic [1:0] size_q;
    logic [1:0] offs_q;
    logic [31:0] buf_q [pbr_pkg::BUF_DEPTH];
    logic wrPtr_q;
    logic rdPtr_q;
    logic [1:0] count_q;
    logic start;
    logic isLine;
    logic push;
    logic pop;
    logic ack;
    logic [3:0] lanes;
    logic [31:0] laneData;

    // Byte lanes that carry the operand, big-endian, lane 3 is the top byte
    function automatic logic [3:0] laneMask(input logic [1:0] size, input logic [1:0] offs);
        logic [3:0] m;
        m = 4'hf;
        if (size == pbr_pkg::SIZE_BYTE) begin
            m = 4'h8 >> offs;
        end else if (size == pbr_pkg::SIZE_WORD) begin
            m = offs[1] ? 4'h3 : 4'hc;
        end
        return m;
    endfunction

    assign start = bus.busCycleStartStrobe && !active_q;
    assign isLine = (bus.sizeBits == pbr_pkg::SIZE_LINE);
    assign push = memRspValid && memRspReady;
    // A full buffer stalls the memory instead of dropping a word
    assign memRspReady = (count_q != pbr_pkg::BUF_FULL);
    assign ack = active_q && (count_q != 2'h0);
    assign pop = ack;
    assign memReqValid = (reqLeft_q != 3'h0);
    assign memReqAddr = reqAddr_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            active_q <= 1'b0;
            burst_q <= 1'b0;
            line_q <= 1'b0;
            first_q <= 1'b0;
            beatsLeft_q <= 3'h0;
            size_q <= pbr_pkg::SIZE_LONG;
            offs_q <= 2'h0;
        end else if (clkEn) begin
            if (start) begin
                active_q <= 1'b1;
                burst_q <= isLine && canBurst;
                line_q <= isLine;
                first_q <= 1'b1;
                beatsLeft_q <= (isLine && canBurst) ? pbr_pkg::LINE_WORDS
                    : pbr_pkg::SINGLE_WORDS;
                size_q <= bus.sizeBits;
                offs_q <= bus.addr[1:0];
            end else if (pop) begin
                first_q <= 1'b0;
                beatsLeft_q <= beatsLeft_q - 3'h1;
                if (beatsLeft_q == 3'h1) begin
                    active_q <= 1'b0;
                end
            end
        end
    end

    // Word requests; A1/A0 are dropped, bits 3:2 wrap inside the line
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reqLeft_q <= 3'h0;
            reqAddr_q <= pbr_pkg::RESET_WORD;
        end else if (clkEn) begin
            if (start) begin
                reqLeft_q <= (isLine && canBurst) ? pbr_pkg::LINE_WORDS : pbr_pkg::SINGLE_WORDS;
                reqAddr_q <= {bus.addr[31:2], 2'h0};
            end else if (memReqValid && memReqReady) begin
                reqLeft_q <= reqLeft_q - 3'h1;
                reqAddr_q[pbr_pkg::LINE_ADDR_MSB:pbr_pkg::LINE_ADDR_LSB] <=
                    reqAddr_q[pbr_pkg::LINE_ADDR_MSB:pbr_pkg::LINE_ADDR_LSB] + 2'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            count_q <= 2'h0;
        end else if (clkEn) begin
            if (push) begin
                wrPtr_q <= !wrPtr_q;
            end
            if (pop) begin
                rdPtr_q <= !rdPtr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (clkEn && push) begin
            buf_q[wrPtr_q] <= memRspData;
        end
    end

    assign lanes = laneMask(size_q, offs_q);

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gLane
            assign laneData[8*g+7:8*g] = lanes[g] ? buf_q[rdPtr_q][8*g+7:8*g] : 8'h00;
        end
    endgenerate

    assign bus.data = ack ? laneData : pbr_pkg::RESET_WORD;
    assign bus.transferAck = ack;
    // Both inhibits mean something only on the first word of a line
    assign bus.burstInhibit = ack && first_q && line_q && !burst_q;
    assign bus.cacheInhibitIn = ack && first_q && line_q && noCache;
endmodule

// >>> verification/pbr_bus_sva.sv
// Protocol checker for the bus between the read master and the slave
`timescale 1ns/100ps
module pbr_bus_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic busCycleStartStrobe,
    input wire logic cycleInProgress,
    input wire logic readWrite,
    input wire logic [1:0] sizeBits,
    input wire logic [31:0] addr,
    input wire logic [1:0] transferType,
    input wire logic [31:0] data,
    input wire logic transferAck,
    input wire logic burstInhibit,
    input wire logic cacheInhibitIn
);
    // Words still owed by the running cycle; an inhibited first word ends the burst
    logic [2:0] left_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left_q <= 3'h0;
        end else if (busCycleStartStrobe) begin
            left_q <= (sizeBits == pbr_pkg::SIZE_LINE) ? pbr_pkg::LINE_WORDS : pbr_pkg::SINGLE_WORDS;
        end else if (transferAck) begin
            left_q <= (burstInhibit && left_q == pbr_pkg::LINE_WORDS) ? 3'h0 : left_q - 3'h1;
        end
    end
    property p_strobe_short;
        busCycleStartStrobe |=> !busCycleStartStrobe;
    endproperty
    property p_strobe_busy;
        busCycleStartStrobe |-> cycleInProgress && readWrite;
    endproperty
    property p_no_ack_c1;
        busCycleStartStrobe |-> !transferAck;
    endproperty
    property p_ack_wait;
        busCycleStartStrobe |-> ##[1:300] transferAck;
    endproperty
    property p_strobe_after_end;
        busCycleStartStrobe |-> left_q == 3'h0;
    endproperty
    property p_ack_owned;
        transferAck |-> left_q != 3'h0;
    endproperty
    property p_hold;
        cycleInProgress && !busCycleStartStrobe && !transferAck
            |=> $stable(addr) && $stable(sizeBits) && $stable(transferType);
    endproperty
    property p_busy_fall;
        $fell(cycleInProgress) |-> $past(transferAck);
    endproperty
    property p_step;
        transferAck && burstInhibit |=> busCycleStartStrobe && sizeBits == pbr_pkg::SIZE_LONG
            && addr[3:2] == $past(addr[3:2]) + 2'h1 && addr[1:0] == $past(addr[1:0]);
    endproperty
    property p_inh_ack;
        burstInhibit || cacheInhibitIn |-> transferAck;
    endproperty
    property p_bi_first;
        burstInhibit |-> left_q == pbr_pkg::LINE_WORDS;
    endproperty
    property p_idle_data;
        !transferAck |-> data == 32'h0000_0000;
    endproperty
    a_strobe_short: assert property (p_strobe_short) else $error("strobe too long");
    a_strobe_busy: assert property (p_strobe_busy) else $error("start attrs");
    a_no_ack_c1: assert property (p_no_ack_c1) else $error("ack in start");
    a_ack_wait: assert property (p_ack_wait) else $error("no ack");
    a_strobe_after_end: assert property (p_strobe_after_end) else $error("early start");
    a_ack_owned: assert property (p_ack_owned) else $error("stray ack");
    a_hold: assert property (p_hold) else $error("addr moved");
    a_busy_fall: assert property (p_busy_fall) else $error("progress fell early");
    a_step: assert property (p_step) else $error("bad step");
    a_inh_ack: assert property (p_inh_ack) else $error("inhibit alone");
    a_bi_first: assert property (p_bi_first) else $error("late inhibit");
    a_idle_data: assert property (p_idle_data) else $error("data not idle");
    c_burst: cover property (busCycleStartStrobe && sizeBits == pbr_pkg::SIZE_LINE);
    c_inhibit: cover property (transferAck && burstInhibit);
    c_wait: cover property (cycleInProgress && !busCycleStartStrobe && !transferAck);
endmodule

// >>> verification/pbr_tb.sv
// Self-checking bench: master and slave joined, memory and model in the bench
`timescale 1ns/100ps
module pbr_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic reqValid = 1'b0, reqReady, reqLine = 1'b0, reqFetch = 1'b0;
    logic reqBlockMove = 1'b0, reqNoCache = 1'b0, canBurst = 1'b1, noCache = 1'b0;
    logic [31:0] reqAddr = 32'h0000_0000, rspData, memReqAddr, memRspData = 32'h0000_0000;
    logic [1:0] reqSize = 2'h0, reqType = 2'h0, reqUserAttr = 2'h0;
    logic [2:0] reqModifier = 3'h0;
    logic rspValid, rspCacheInhibit, rspLast, busLocked, memReqValid, memRspReady;
    logic memReqReady = 1'b0, memRspValid = 1'b0;
    logic curLine = 1'b0, curFetch = 1'b0, curCio = 1'b0;
    logic [1:0] curSz = 2'h0;
    logic [6:0] curAttr = 7'h00;
    logic [31:0] curA = 32'h0000_0000;
    logic [31:0] r, a, memQ[$], expW[$];
    logic expL[$], expC[$];
    int n_errors = 0, comparisons = 0, seed = 56418;
    always #5 clk = ~clk;
    pbr_if bus();
    pbr_master i_pbr_master (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .bus(bus.master),
        .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr), .reqSize(reqSize),
        .reqLine(reqLine), .reqFetch(reqFetch), .reqBlockMove(reqBlockMove),
        .reqNoCache(reqNoCache), .reqType(reqType), .reqModifier(reqModifier),
        .reqUserAttr(reqUserAttr), .rspValid(rspValid), .rspData(rspData),
        .rspCacheInhibit(rspCacheInhibit), .rspLast(rspLast), .busLocked(busLocked));
    pbr_slave i_pbr_slave (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .bus(bus.slave),
        .canBurst(canBurst), .noCache(noCache), .memReqValid(memReqValid),
        .memReqReady(memReqReady), .memReqAddr(memReqAddr), .memRspValid(memRspValid),
        .memRspReady(memRspReady), .memRspData(memRspData));
    pbr_bus_sva i_pbr_bus_sva (.clk(clk), .rst_b(rst_b),
        .busCycleStartStrobe(bus.busCycleStartStrobe), .cycleInProgress(bus.cycleInProgress),
        .readWrite(bus.readWrite), .sizeBits(bus.sizeBits), .addr(bus.addr),
        .transferType(bus.transferType), .data(bus.data), .transferAck(bus.transferAck),
        .burstInhibit(bus.burstInhibit), .cacheInhibitIn(bus.cacheInhibitIn));
    function automatic logic [31:0] memf(input logic [31:0] x);
        return {x[15:0], ~x[15:0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Memory answers in order with random stalls; a released data line toggles
    always @(posedge clk) begin
        if (memReqValid === 1'b1 && memReqReady === 1'b1) memQ.push_back(memReqAddr);
        if (memRspValid === 1'b1 && memRspReady === 1'b1) begin
            void'(memQ.pop_front());
            memRspValid <= 1'b0;
        end
    end
    always @(negedge clk) begin
        memReqReady <= ($random(seed) & 3) != 0;
        if (!memRspValid) begin
            if (memQ.size() > 0 && ($random(seed) & 1)) begin
                memRspValid <= 1'b1;
                memRspData <= memf(memQ[0]);
            end else begin
                memRspData <= ~memRspData;
            end
        end
    end
    task automatic issue(input logic [31:0] x, input logic [1:0] sz, input logic ln, fe, bm);
        logic [1:0] st;
        logic [31:0] w;
        @(negedge clk);
        reqValid = 1'b1;
        reqAddr = x;
        reqSize = sz;
        reqLine = ln;
        reqFetch = fe;
        reqBlockMove = bm;
        reqNoCache = $random(seed);
        {reqType, reqModifier, reqUserAttr} = 7'($random(seed));
        while (reqReady !== 1'b1) @(negedge clk);
        @(posedge clk);
        {curLine, curFetch, curCio, curSz} = {ln, fe, bm & reqNoCache, sz};
        curAttr = {reqType, reqModifier, reqUserAttr};
        curA = (fe && ln) ? {x[31:3], 3'h0} : x;
        st = fe ? {x[3], 1'b0} : x[3:2];
        for (int k = 0; k < (ln ? 4 : 1); k++) begin
            w = memf(ln ? {x[31:4], st + k[1:0], 2'b00} : {x[31:2], 2'b00});
            if (!ln && sz == pbr_pkg::SIZE_BYTE) w &= 32'hFF00_0000 >> (8 * x[1:0]);
            if (!ln && sz == pbr_pkg::SIZE_WORD) w &= 32'hFFFF_0000 >> (8 * x[1:0]);
            expW.push_back(w);
            expL.push_back(!ln || k == 3);
            expC.push_back(ln & noCache);
        end
    endtask
    always @(posedge clk) begin
        if (bus.busCycleStartStrobe === 1'b1) begin
            check(busLocked, curLine);
            check(bus.addr, curA);
            check({bus.transferType, bus.transferModifier, bus.userAttributeOutputs},
                curAttr);
            check(bus.cacheInhibitOut, curLine ? curCio : 1'b1);
            // A refused burst restarts one long word further on, low bits kept
            curA[3:2] = curA[3:2] + 2'h1;
            if (bus.sizeBits === pbr_pkg::SIZE_LINE) begin
                check(curLine, 1'b1);
                if (curFetch) check(bus.addr[2:0], 3'h0);
            end else if (!curLine) begin
                check(bus.sizeBits, curSz);
            end else begin
                check(bus.sizeBits, pbr_pkg::SIZE_LONG);
            end
        end
        if (rspValid === 1'b1) begin
            if (expW.size() == 0) begin
                check(1'b1, 1'b0);
            end else begin
                check(rspData, expW.pop_front());
                check(rspLast, expL.pop_front());
                check(rspCacheInhibit, expC.pop_front());
            end
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        issue(32'h1000_000C, pbr_pkg::SIZE_LINE, 1'b1, 1'b1, 1'b0);
        // Config changes only when idle, since the slave samples it mid-cycle
        for (int c = 0; c < 4; c++) begin
            for (int n = 0; n < 16; n++) begin
                r = $random(seed);
                a = $random(seed);
                if (r[2:0] == 3'h0) issue(a, pbr_pkg::SIZE_BYTE, 1'b0, 1'b0, 1'b0);
                else if (r[2:0] == 3'h1) issue(a & 32'hFFFF_FFFE, pbr_pkg::SIZE_WORD, 1'b0, 1'b0, 1'b0);
                else if (r[2:0] == 3'h2) issue(a & 32'hFFFF_FFFC, pbr_pkg::SIZE_LONG, 1'b0, 1'b0, 1'b0);
                else issue(a, pbr_pkg::SIZE_LINE, 1'b1, r[3], r[4]);
            end
            @(negedge clk);
            reqValid = 1'b0;
            for (int i = 0; i < 3000 && (expW.size() > 0 || bus.cycleInProgress); i++) @(negedge clk);
            check(32'(expW.size()), 32'h0000_0000);
            {noCache, canBurst} = c[1:0] + 2'h1;
        end
        end_of_test();
    end
    initial begin
        #300000;
        n_errors++;
        end_of_test();
    end
endmodule
